/* File: core/slc_stack_limit_checker.sv */
/*
  Software stack pointer and stack bounds checker for a 16-bit core.
  Assumes the address generation logic presents one stack operation per cycle on
  i_op, and that the trap logic samples o_stack_err as a one-cycle pulse.
*/
// Behaviour
// - Working register fifteen serves as both general register and stack pointer.
// - Pointer addresses the first free word; stack grows upward.
// - Push writes at pointer then increments; pop decrements then reads.
// - Call pushes of the program counter clear the upper bit.
// - Exception pushes put the status low byte in the upper byte.
// - Stack limit register is not touched by reset.
// - Bit zero of the stack limit always reads as zero; it acts as zero once the limit is written.
// - Each stack-pointer effective address is compared with the limit.
// - Push at pointer equal to limit passes; the next push traps.
// - Pointer below the fixed lower boundary raises a stack error.
`include "slc_consts.svh"
`default_nettype none
module slc_stack_limit_checker
  import slc_pkg::*;
#(
  parameter int WORD_W = `SLC_WORD_W
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire slc_op_type i_op,
  input wire slc_push_kind_type i_push_kind,
  input wire logic [WORD_W-1:0] i_push_data,
  input wire logic [`SLC_PC_W-1:0] i_pc,
  input wire logic [7:0] i_status_low_byte,
  input wire logic [WORD_W-1:0] i_ea,
  input wire logic i_wreg_we,
  input wire logic [WORD_W-1:0] i_wreg_wdata,
  input wire logic i_limit_we,
  input wire logic [WORD_W-1:0] i_limit_wdata,
  output logic [WORD_W-1:0] o_sw_stack_pointer,
  output logic [WORD_W-1:0] o_stack_limit_reg,
  output logic o_mem_we,
  output logic o_mem_re,
  output logic [WORD_W-1:0] o_mem_addr,
  output logic [WORD_W-1:0] o_mem_wdata,
  output logic o_stack_err
);

  logic [WORD_W-1:0] sw_stack_pointer;
  logic [WORD_W-1:0] next_sw_stack_pointer;
  logic [WORD_W-1:0] stack_limit_reg;
  logic [WORD_W-1:0] next_stack_limit_reg;
  logic mem_we;
  logic next_mem_we;
  logic mem_re;
  logic next_mem_re;
  logic [WORD_W-1:0] mem_addr;
  logic [WORD_W-1:0] next_mem_addr;
  logic [WORD_W-1:0] mem_wdata;
  logic [WORD_W-1:0] next_mem_wdata;
  logic stack_err;
  logic next_stack_err;
  logic [WORD_W-1:0] pop_addr;
  logic [WORD_W-1:0] check_addr;
  logic over_limit;
  logic under_bound;

  // Pointer steps by one word and pops address the decremented pointer
  assign pop_addr = sw_stack_pointer - WORD_W'(`SLC_WORD_STEP);

  // Address that the bounds check looks at for this operation
  always_comb begin
    check_addr = i_ea;
    unique case (i_op)
      SLC_OP_PUSH: check_addr = sw_stack_pointer;
      SLC_OP_POP: check_addr = pop_addr;
      SLC_OP_EA: check_addr = i_ea;
      SLC_OP_NONE: check_addr = i_ea;
    endcase
  end

  // Strictly above the limit traps, so a push at the limit itself passes
  assign over_limit = (i_op != SLC_OP_NONE) && (check_addr > stack_limit_reg);
  assign under_bound = (i_op != SLC_OP_NONE) && (check_addr < WORD_W'(`SLC_LOWER_BOUND));

  // Pointer, limit and memory request next values
  always_comb begin
    next_sw_stack_pointer = sw_stack_pointer;
    next_stack_limit_reg = stack_limit_reg;
    next_mem_we = 1'b0;
    next_mem_re = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_stack_err = over_limit || under_bound;
    // Limit is word aligned; bit zero never stored as one
    if (i_limit_we) begin
      next_stack_limit_reg = {i_limit_wdata[WORD_W-1:1], 1'b0};
    end
    // Same register also takes plain working-register writes; alignment kept
    if (i_wreg_we) begin
      next_sw_stack_pointer = {i_wreg_wdata[WORD_W-1:1], 1'b0};
    end
    unique case (i_op)
      SLC_OP_PUSH: begin
        // Store at the free word, then step past it
        next_mem_we = 1'b1;
        next_mem_addr = sw_stack_pointer;
        next_sw_stack_pointer = sw_stack_pointer + WORD_W'(`SLC_WORD_STEP);
        unique case (i_push_kind)
          SLC_PUSH_CALL: next_mem_wdata = {1'b0, i_pc[WORD_W-2:0]};
          SLC_PUSH_EXC: next_mem_wdata = WORD_W'({i_status_low_byte, i_pc[7:0]});
          SLC_PUSH_DATA: next_mem_wdata = i_push_data;
          default: next_mem_wdata = i_push_data;
        endcase
      end
      SLC_OP_POP: begin
        next_mem_re = 1'b1;
        next_mem_addr = pop_addr;
        next_sw_stack_pointer = pop_addr;
      end
      SLC_OP_EA: begin
      end
      SLC_OP_NONE: begin
      end
    endcase
  end

  // Pointer and outputs take reset; the limit does not, software loads it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sw_stack_pointer <= WORD_W'(`SLC_SP_RESET);
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
      stack_err <= 1'b0;
    end else begin
      sw_stack_pointer <= next_sw_stack_pointer;
      mem_we <= next_mem_we;
      mem_re <= next_mem_re;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      stack_err <= next_stack_err;
    end
  end

  // Deliberately outside the reset branch
  always_ff @(posedge i_clk) begin
    stack_limit_reg <= next_stack_limit_reg;
  end

  assign o_sw_stack_pointer = sw_stack_pointer;
  assign o_stack_limit_reg = {stack_limit_reg[WORD_W-1:1], 1'b0};
  assign o_mem_we = mem_we;
  assign o_mem_re = mem_re;
  assign o_mem_addr = mem_addr;
  assign o_mem_wdata = mem_wdata;
  assign o_stack_err = stack_err;

  // Push moves the pointer up one word
  property p_push_step;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_PUSH && !i_wreg_we) |=> (sw_stack_pointer == $past(sw_stack_pointer) + WORD_W'(`SLC_WORD_STEP));
  endproperty
  a_push_step: assert property (p_push_step) else $error("push did not step pointer by two");

  // Pop reads the word it has just stepped back onto
  property p_pop_addr;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_POP && !i_wreg_we) |=> (mem_re && mem_addr == sw_stack_pointer);
  endproperty
  a_pop_addr: assert property (p_pop_addr) else $error("pop did not read decremented pointer");

  // Push stores at the free word the pointer held before the step
  property p_push_addr;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_PUSH) |=> (mem_we && mem_addr == $past(sw_stack_pointer));
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push wrote wrong address");

  // Call return address never carries a set top bit
  property p_call_msb;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_PUSH && i_push_kind == SLC_PUSH_CALL) |=> !mem_wdata[WORD_W-1];
  endproperty
  a_call_msb: assert property (p_call_msb) else $error("call push upper bit set");

  // Exception push saves the status byte so the return can restore it
  property p_exc_srl;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_PUSH && i_push_kind == SLC_PUSH_EXC) |=> (mem_wdata[WORD_W-1:WORD_W-8] == $past(i_status_low_byte));
  endproperty
  a_exc_srl: assert property (p_exc_srl) else $error("exception push lacks status byte");

  // Limit seen by software is always word aligned, even before it is written
  property p_limit_bit0;
    @(posedge i_clk) o_stack_limit_reg[0] == 1'b0;
  endproperty
  a_limit_bit0: assert property (p_limit_bit0) else $error("limit bit zero set");

  // The limit word itself is still usable stack
  property p_at_limit_ok;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_PUSH && sw_stack_pointer == stack_limit_reg &&
      sw_stack_pointer >= WORD_W'(`SLC_LOWER_BOUND)) |=> !stack_err;
  endproperty
  a_at_limit_ok: assert property (p_at_limit_ok) else $error("push at limit trapped");

  // Any stack-pointer address above the limit traps
  property p_over_trap;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_EA && i_ea > stack_limit_reg) |=> stack_err;
  endproperty
  a_over_trap: assert property (p_over_trap) else $error("address above limit not trapped");

  // Addresses below the boundary would reach register space
  property p_under_trap;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_EA && i_ea < WORD_W'(`SLC_LOWER_BOUND)) |=> stack_err;
  endproperty
  a_under_trap: assert property (p_under_trap) else $error("underflow not trapped");

  // Plain register writes land in the pointer, aligned
  property p_wreg_write;
    @(posedge i_clk) disable iff (i_srst)
    (i_wreg_we && i_op == SLC_OP_NONE) |=> (sw_stack_pointer == {$past(i_wreg_wdata[WORD_W-1:1]), 1'b0});
  endproperty
  a_wreg_write: assert property (p_wreg_write) else $error("register write lost");

  // Pop walks the pointer back one word even when a register write collides
  property p_pop_step;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_POP) |=> (sw_stack_pointer == $past(sw_stack_pointer) - WORD_W'(`SLC_WORD_STEP));
  endproperty
  a_pop_step: assert property (p_pop_step) else $error("pop did not step pointer back by two");

  // An odd pointer would split a word across two stack slots
  property p_sp_align;
    @(posedge i_clk) disable iff (i_srst)
    sw_stack_pointer[0] == 1'b0;
  endproperty
  a_sp_align: assert property (p_sp_align) else $error("pointer not word aligned");

  // Plain data pushes carry the operand untouched
  property p_push_data;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_PUSH && i_push_kind == SLC_PUSH_DATA) |=> (mem_wdata == $past(i_push_data));
  endproperty
  a_push_data: assert property (p_push_data) else $error("data push stored wrong word");

  // Call pushes keep the low program counter bits below the cleared top bit
  property p_call_low;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_PUSH && i_push_kind == SLC_PUSH_CALL) |=> (mem_wdata[WORD_W-2:0] == $past(i_pc[WORD_W-2:0]));
  endproperty
  a_call_low: assert property (p_call_low) else $error("call push lost program counter bits");

  // Exception pushes keep the program counter low byte under the status byte
  property p_exc_low;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_PUSH && i_push_kind == SLC_PUSH_EXC) |=> (mem_wdata[7:0] == $past(i_pc[7:0]));
  endproperty
  a_exc_low: assert property (p_exc_low) else $error("exception push lost program counter byte");

  // A new limit is used from the next cycle, with bit zero dropped
  property p_limit_load;
    @(posedge i_clk) disable iff (i_srst)
    i_limit_we |=> (stack_limit_reg == {$past(i_limit_wdata[WORD_W-1:1]), 1'b0});
  endproperty
  a_limit_load: assert property (p_limit_load) else $error("limit write not stored aligned");

  // Idle cycles raise no strobe and no trap
  property p_idle_quiet;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_NONE) |=> (!mem_we && !mem_re && !stack_err);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle cycle raised a strobe or trap");

  // Popping from the boundary reads below it, which must trap
  property p_pop_under;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_POP && sw_stack_pointer == WORD_W'(`SLC_LOWER_BOUND)) |=> stack_err;
  endproperty
  a_pop_under: assert property (p_pop_under) else $error("pop below boundary not trapped");

  // One word past the limit is the first push that traps
  property p_next_push_trap;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_PUSH && sw_stack_pointer == stack_limit_reg + WORD_W'(`SLC_WORD_STEP)) |=> stack_err;
  endproperty
  a_next_push_trap: assert property (p_next_push_trap) else $error("push past limit not trapped");

  // Address and data stay put between stack operations, so a late read sees the last access
  property p_hold_addr;
    @(posedge i_clk) disable iff (i_srst)
    (i_op == SLC_OP_NONE || i_op == SLC_OP_EA) |=> (mem_addr == $past(mem_addr) && mem_wdata == $past(mem_wdata));
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("memory address or data moved while idle");

  // Main scenarios: push, pop, trap, exception push and the limit crossing
  c_exc: cover property (@(posedge i_clk) disable iff (i_srst) i_op == SLC_OP_PUSH && i_push_kind == SLC_PUSH_EXC ##1 mem_we);
  c_push: cover property (@(posedge i_clk) disable iff (i_srst) i_op == SLC_OP_PUSH ##1 !stack_err);
  c_pop: cover property (@(posedge i_clk) disable iff (i_srst) i_op == SLC_OP_POP ##1 mem_re);
  c_err: cover property (@(posedge i_clk) disable iff (i_srst) stack_err);
  c_limit_push: cover property (@(posedge i_clk) disable iff (i_srst)
    i_op == SLC_OP_PUSH && sw_stack_pointer == stack_limit_reg ##1 i_op == SLC_OP_PUSH ##1 stack_err);

endmodule
`default_nettype wire

/* File: core/slc_consts.svh */
/*
  Constants for the stack limit checker: field positions, boundaries and reset values.
  Assumes it is included by its bare name from the design files.
*/
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH
`define SLC_WORD_W 16
`define SLC_LOWER_BOUND 16'h0800
`define SLC_SP_RESET 16'h0800
`define SLC_WORD_STEP 16'h0002
`define SLC_PC_MSB 22
`define SLC_PC_W 23
`endif

/* File: core/slc_pkg.sv */
/*
  Types for the stack limit checker.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package slc_pkg;
  typedef enum logic [1:0] {
    SLC_OP_NONE = 2'b00,
    SLC_OP_PUSH = 2'b01,
    SLC_OP_POP = 2'b10,
    SLC_OP_EA = 2'b11
  } slc_op_type;
  typedef enum logic [1:0] {
    SLC_PUSH_DATA = 2'b00,
    SLC_PUSH_CALL = 2'b01,
    SLC_PUSH_EXC = 2'b10
  } slc_push_kind_type;
endpackage
`default_nettype wire

/* File: test/slc_core_model.sv */
/* Trap side of the core: counts stack error pulses.
   Assumes the error output is a one-cycle pulse. */
`default_nettype none
module slc_core_model (
  input wire logic i_clk,
  input wire logic i_err,
  output var int o_traps
);
  timeunit 1ns;
  timeprecision 1ps;
  int trap_cnt = 0;
  // A level instead of a pulse would count once per cycle
  always @(posedge i_clk) begin
    if (i_err) trap_cnt <= trap_cnt + 1;
  end
  // One driver for the count seen by the bench
  assign o_traps = trap_cnt;
endmodule
`default_nettype wire

/* File: test/slc_stack_limit_checker_tb.sv */
/* Bench for the stack limit checker with a reference model.
   Assumes the design files and the core model are compiled first. */
`default_nettype none
module slc_stack_limit_checker_tb
  import slc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_srst = 1, i_wreg_we = 0, i_limit_we = 0;
  slc_op_type i_op = SLC_OP_NONE;
  slc_push_kind_type i_push_kind = SLC_PUSH_DATA;
  logic [15:0] i_push_data = 0, i_ea = 0, i_wreg_wdata = 0, i_limit_wdata = 0;
  logic [22:0] i_pc = 0;
  logic [7:0] i_status_low_byte = 0;
  logic [15:0] o_sw_stack_pointer, o_stack_limit_reg, o_mem_addr, o_mem_wdata;
  logic o_mem_we, o_mem_re, o_stack_err;
  int error_cnt = 0, n_tests = 0, cyc = 0, traps, etraps = 0;
  logic [31:0] rs = 52;
  logic [15:0] sp, lim;
  // Clock at 40 MHz
  always #12.5 i_clk = ~i_clk;
  slc_stack_limit_checker u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_op(i_op), .i_push_kind(i_push_kind),
    .i_push_data(i_push_data), .i_pc(i_pc), .i_status_low_byte(i_status_low_byte), .i_ea(i_ea),
    .i_wreg_we(i_wreg_we), .i_wreg_wdata(i_wreg_wdata), .i_limit_we(i_limit_we),
    .i_limit_wdata(i_limit_wdata), .o_sw_stack_pointer(o_sw_stack_pointer),
    .o_stack_limit_reg(o_stack_limit_reg), .o_mem_we(o_mem_we), .o_mem_re(o_mem_re),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_stack_err(o_stack_err));
  slc_core_model u_core (.i_clk(i_clk), .i_err(o_stack_err), .o_traps(traps));
  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[15:0];
  endfunction
  // One operation; v feeds the address, pointer and limit write values
  task automatic step(input slc_op_type op, input slc_push_kind_type k, input logic w, input logic l,
      input logic [15:0] v);
    logic [15:0] a, d;
    logic e;
    i_op = op;
    i_push_kind = k;
    i_wreg_we = w;
    i_limit_we = l;
    i_ea = v;
    i_wreg_wdata = v;
    i_limit_wdata = v;
    i_push_data = rnd();
    i_pc = 23'({rnd(), rnd()});
    i_status_low_byte = 8'(rnd());
    a = (op == SLC_OP_POP) ? sp - 16'h0002 : (op == SLC_OP_EA) ? v : sp;
    e = (op != SLC_OP_NONE) && (a > lim || a < 16'h0800);
    d = (k == SLC_PUSH_CALL) ? {1'b0, i_pc[14:0]} : (k == SLC_PUSH_EXC) ? {i_status_low_byte, i_pc[7:0]} : i_push_data;
    @(posedge i_clk);
    #1;
    // Push and pop win over a plain register write
    if (op == SLC_OP_PUSH) sp += 16'h0002;
    else if (op == SLC_OP_POP) sp -= 16'h0002;
    else if (w) sp = v & 16'hfffe;
    if (l) lim = v & 16'hfffe;
    etraps += int'(e);
    chk(o_sw_stack_pointer, sp);
    chk(16'(o_stack_err), 16'(e));
    chk(16'(o_mem_we), 16'(op == SLC_OP_PUSH));
    chk(16'(o_mem_re), 16'(op == SLC_OP_POP));
    if (op inside {SLC_OP_PUSH, SLC_OP_POP}) chk(o_mem_addr, a);
    if (op == SLC_OP_PUSH) chk(o_mem_wdata, d);
    if (l) chk(o_stack_limit_reg, lim);
  endtask
  // Hang guard, well above the expected run length
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  // Directed cases, then random traffic against the model
  initial begin
    repeat (20) @(posedge i_clk);
    #1;
    i_srst = 0;
    sp = 16'h0800;
    chk(o_sw_stack_pointer, sp);
    chk(16'(o_stack_limit_reg[0]), 16'h0000);
    step(SLC_OP_NONE, SLC_PUSH_DATA, 0, 1, 16'h0811);
    repeat (10) step(SLC_OP_PUSH, SLC_PUSH_DATA, 0, 0, 16'h0000);
    step(SLC_OP_PUSH, SLC_PUSH_CALL, 0, 0, 16'h0000);
    step(SLC_OP_PUSH, SLC_PUSH_EXC, 0, 0, 16'h0000);
    step(SLC_OP_NONE, SLC_PUSH_DATA, 1, 0, 16'h0803);
    repeat (2) step(SLC_OP_POP, SLC_PUSH_DATA, 0, 0, 16'h0000);
    step(SLC_OP_EA, SLC_PUSH_DATA, 0, 0, 16'h0810);
    step(SLC_OP_EA, SLC_PUSH_DATA, 0, 0, 16'h0812);
    step(SLC_OP_EA, SLC_PUSH_DATA, 0, 0, 16'h07fe);
    // Limit write kept apart from stack reads by an idle cycle
    step(SLC_OP_NONE, SLC_PUSH_DATA, 0, 1, 16'h0900);
    step(SLC_OP_NONE, SLC_PUSH_DATA, 0, 0, 16'h0000);
    // Mid-run reset: the pointer restarts, the limit keeps what software wrote
    i_srst = 1;
    repeat (2) @(posedge i_clk);
    #1;
    i_srst = 0;
    sp = 16'h0800;
    chk(o_sw_stack_pointer, sp);
    chk(o_stack_limit_reg, lim);
    repeat (2000) step(slc_op_type'(2'(rnd())), slc_push_kind_type'(2'(rnd() % 3)), rnd() > 16'he000, 0,
      rnd() & 16'h0fff);
    step(SLC_OP_NONE, SLC_PUSH_DATA, 0, 0, 16'h0000);
    chk(16'(traps), 16'(etraps));
    final_report();
  end
endmodule
`default_nettype wire
